// >>> core/wfs_cnt_if.sv
// Carrier between the status register and its counters
`timescale 1ns/1ps
`include "wfs_defines.svh"

interface wfs_cnt_if;
   logic                       restart_event;
   logic                       wd_fail;
   logic                       wd_trigger_ok;
   logic [`WFS_RESTART_W-1:0]  restart_count;
   logic [`WFS_WDCNT_W-1:0]    wd_count;

   modport status (
      output restart_event,
      output wd_fail,
      output wd_trigger_ok,
      input  restart_count,
      input  wd_count
   );

   modport counters (
      input  restart_event,
      input  wd_fail,
      input  wd_trigger_ok,
      output restart_count,
      output wd_count
   );
endinterface : wfs_cnt_if

// >>> core/wfs_counters.sv
// Restart and watchdog failure counters, immune to read-and-clear
`timescale 1ns/1ps
`include "wfs_defines.svh"

module wfs_counters #(
   parameter int unsigned RESTART_WIN_CYC = `WFS_RESTART_WIN_CYC
) (
   input  wire logic     ref_clk_in,
   input  wire logic     rst_in,
   wfs_cnt_if.counters   cnt
);
   import wfs_pkg::*;

   logic [30:0]                 quiet_timer;
   logic                        quiet_armed;
   logic [`WFS_RESTART_W-1:0]   restart_count;
   logic [`WFS_WDCNT_W-1:0]     wd_count;
   logic                        quiet_done;
   logic                        restart_full;
   logic                        wd_full;

   // Window end and saturation decode
   assign quiet_done   = (quiet_timer == 31'(RESTART_WIN_CYC - 1));
   assign restart_full = &restart_count;
   assign wd_full      = &wd_count;

   // Restart count, cleared after a quiet minute
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         restart_count <= '0;
         quiet_timer   <= '0;
         quiet_armed   <= 1'b0;
      end else if (cnt.restart_event) begin // see RL7
         restart_count <= restart_count + {{(`WFS_RESTART_W-1){1'b0}},
                                           !restart_full};
         quiet_timer   <= '0;
         quiet_armed   <= 1'b1;
      end else if (quiet_armed && quiet_done) begin // see RL7
         restart_count <= '0;
         quiet_timer   <= '0;
         quiet_armed   <= 1'b0;
      end else if (quiet_armed) begin
         quiet_timer   <= quiet_timer + 31'h1;
      end
   end

   // Consecutive watchdog failures, cleared by a good trigger
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wd_count <= '0;
      end else if (cnt.wd_fail) begin // see RL8
         wd_count <= wd_count + {{(`WFS_WDCNT_W-1){1'b0}}, !wd_full};
      end else if (cnt.wd_trigger_ok) begin // see RL8
         wd_count <= '0;
      end
   end

   assign cnt.restart_count = restart_count;
   assign cnt.wd_count      = wd_count;

endmodule : wfs_counters

// >>> core/wfs_defines.svh
// Constants for the wake and fault status register
`ifndef WFS_DEFINES_SVH
`define WFS_DEFINES_SVH

// Register geometry and placement
`define WFS_DATA_W          24
`define WFS_ADDR_W          6
`define WFS_ADDR_STATUS     6'h08

// Single flag positions
`define WFS_BIT_IRQ2_WAKE   23
`define WFS_BIT_IRQ1_WAKE   20
`define WFS_BIT_CAN_WAKE    19
`define WFS_BIT_LIN_WAKE    18
`define WFS_BIT_TIMER_WAKE  17
`define WFS_BIT_DEBUG       16
`define WFS_BIT_MAIN_UV     15
`define WFS_BIT_THERM2      5
`define WFS_BIT_THERM1      4
`define WFS_BIT_FS_THERMAL  3
`define WFS_BIT_FS_WD       2
`define WFS_BIT_WD_FAIL     1
`define WFS_BIT_POR         0

// Multi-bit fields
`define WFS_RESTART_LSB     12
`define WFS_RESTART_W       3
`define WFS_WDCNT_LSB       8
`define WFS_WDCNT_W         4
`define WFS_STATE_LSB       6
`define WFS_STATE_W         2

// Latched flags cleared by read-and-clear; reserved bits 22:21 excluded
`define WFS_FLAG_MASK       24'h9F803F
// Flag value after reset: power-on flag set
`define WFS_FLAG_RESET      24'h000001

// Device state encodings
`define WFS_STATE_ACTIVE    2'h0
`define WFS_STATE_MAIN_SBY  2'h1
`define WFS_STATE_VBAT_SBY  2'h2

// Restart counter quiet window
`define WFS_CLK_HZ          25000000
`define WFS_RESTART_WIN_S   60
`define WFS_RESTART_WIN_CYC (`WFS_RESTART_WIN_S * `WFS_CLK_HZ)

`endif

// >>> core/wfs_pkg.sv
// Types shared by the wake and fault status register
package wfs_pkg;

   // Access kinds decoded from a serial frame
   typedef enum logic [1:0] {
      WFS_OP_READ       = 2'h0,
      WFS_OP_READ_CLEAR = 2'h1,
      WFS_OP_WRITE      = 2'h2,
      WFS_OP_NONE       = 2'h3
   } wfs_op_e;

   typedef logic [23:0] wfs_word_t;

endpackage : wfs_pkg

// >>> core/wfs_status.sv
// Wake-up and fault status register with read-and-clear access
//
// How it works
// RL1: Interrupt-two sets bit 23, interrupt-one bit 20.
// RL2: CAN wake-up latches bit 19.
// RL3: LIN wake-up latches bit 18.
// RL4: Timer wake-up latches bit 17.
// RL5: Active debug mode latches bit 16.
// RL6: Main regulator undervoltage latches bit 15.
// RL7: Bits 14:12 count restarts, cleared after quiet minute.
// RL8: Bits 11:8 count watchdog failures, good trigger clears.
// RL9: Bits 7:6 encode the device state.
// RL10: State held until read-and-clear, then refreshed.
// RL11: Thermal stage two latches bit 5.
// RL12: Thermal stage one latches bit 4.
// RL13: Thermal or short forced sleep latches bit 3.
// RL14: Watchdog forced sleep latches bit 2.
// RL15: Any watchdog failure latches bit 1.
// RL16: Power-on reset latches bit 0.
// RL17: Writes ignored and reported as invalid commands.
// RL18: Read-and-clear returns contents, clears flags, keeps events.
// RL19: Bits 22 and 21 always read zero.
`timescale 1ns/1ps
`include "wfs_defines.svh"

module wfs_status #(
   parameter int unsigned RESTART_WIN_CYC = `WFS_RESTART_WIN_CYC
) (
   input  wire logic                     ref_clk_in,
   input  wire logic                     rst_in,
   // Wake-up sources, one-cycle pulses from the wake logic
   input  wire logic                     ext_irq_two_wake_in,
   input  wire logic                     ext_irq_one_wake_in,
   input  wire logic                     can_wake_in,
   input  wire logic                     lin_wake_in,
   input  wire logic                     timer_wake_in,
   // Standby exit and which standby it was
   input  wire logic                     standby_wake_in,
   input  wire logic                     vbat_standby_in,
   // Levels and pulses from supervision logic
   input  wire logic                     debug_active_in,
   input  wire logic                     main_regulator_uv_in,
   input  wire logic                     thermal_stage_two_in,
   input  wire logic                     thermal_stage_one_in,
   input  wire logic                     main_regulator_restart_in,
   input  wire logic                     forced_sleep_thermal_in,
   input  wire logic                     forced_sleep_watchdog_in,
   input  wire logic                     watchdog_fail_in,
   input  wire logic                     watchdog_trigger_ok_in,
   input  wire logic                     power_on_reset_in,
   // Decoded serial access
   input  wire logic                     acc_valid_in,
   input  wire logic [`WFS_ADDR_W-1:0]   acc_addr_in,
   input  wire wfs_pkg::wfs_op_e         acc_op_in,
   // Answer to the serial logic
   output logic [`WFS_DATA_W-1:0]        rd_data_out,
   output logic                          rd_valid_out,
   output logic                          invalid_cmd_out
);
   import wfs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Place one event at its bit position
   function automatic wfs_word_t wfs_place(input int unsigned pos,
                                           input logic        value);
      wfs_word_t word;
      word      = '0;
      word[pos] = value;
      return word;
   endfunction : wfs_place

   // Place a field at its low bit position
   function automatic wfs_word_t wfs_field(input int unsigned pos,
                                           input logic [3:0]  value);
      wfs_word_t word;
      word = wfs_word_t'(value) << pos;
      return word;
   endfunction : wfs_field

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   wfs_word_t                   flags;
   wfs_word_t                   next_flags;
   wfs_word_t                   set_vec;
   wfs_word_t                   clr_vec;
   wfs_word_t                   contents;
   logic [`WFS_STATE_W-1:0]     dev_state;
   logic [`WFS_STATE_W-1:0]     next_dev_state;
   logic [`WFS_STATE_W-1:0]     wake_state;
   logic                        addr_hit;
   logic                        read_hit;
   logic                        clear_hit;
   logic                        write_hit;
   logic [`WFS_DATA_W-1:0]      next_rd_data;
   logic                        next_rd_valid;
   logic                        next_invalid_cmd;
   logic [`WFS_RESTART_W-1:0]   restart_count;
   logic [`WFS_WDCNT_W-1:0]     wd_count;

   wfs_cnt_if cnt_bus ();

   ////////////////////////////////////////////////////////////////////////
   // Access decode

   // Only this register's address is answered here
   assign addr_hit  = acc_valid_in && (acc_addr_in == `WFS_ADDR_STATUS);
   assign read_hit  = addr_hit && (acc_op_in == WFS_OP_READ);
   assign clear_hit = addr_hit && (acc_op_in == WFS_OP_READ_CLEAR);
   assign write_hit = addr_hit && (acc_op_in == WFS_OP_WRITE); // see RL17

   ////////////////////////////////////////////////////////////////////////
   // Event collection

   // Wake-up sources and supervision events
   assign set_vec =
        wfs_place(`WFS_BIT_IRQ2_WAKE,  ext_irq_two_wake_in)      // see RL1
      | wfs_place(`WFS_BIT_IRQ1_WAKE,  ext_irq_one_wake_in)      // see RL1
      | wfs_place(`WFS_BIT_CAN_WAKE,   can_wake_in)              // see RL2
      | wfs_place(`WFS_BIT_LIN_WAKE,   lin_wake_in)              // see RL3
      | wfs_place(`WFS_BIT_TIMER_WAKE, timer_wake_in)            // see RL4
      | wfs_place(`WFS_BIT_DEBUG,      debug_active_in)          // see RL5
      | wfs_place(`WFS_BIT_MAIN_UV,    main_regulator_uv_in)     // see RL6
      | wfs_place(`WFS_BIT_THERM2,     thermal_stage_two_in)     // see RL11
      | wfs_place(`WFS_BIT_THERM1,     thermal_stage_one_in)     // see RL12
      | wfs_place(`WFS_BIT_FS_THERMAL, forced_sleep_thermal_in)  // see RL13
      | wfs_place(`WFS_BIT_FS_WD,      forced_sleep_watchdog_in) // see RL14
      | wfs_place(`WFS_BIT_WD_FAIL,    watchdog_fail_in)         // see RL15
      | wfs_place(`WFS_BIT_POR,        power_on_reset_in);       // see RL16

   // Read-and-clear wipes latched flags here, state refreshed below, counters untouched
   assign clr_vec = clear_hit ? wfs_word_t'(`WFS_FLAG_MASK) : '0; // see RL18

   // Set wins over a clear in the same cycle; reserved stay zero
   assign next_flags = ((flags & ~clr_vec) | set_vec)
                       & wfs_word_t'(`WFS_FLAG_MASK); // see RL18 RL19

   ////////////////////////////////////////////////////////////////////////
   // Device state field

   // Code for the standby just left
   assign wake_state = vbat_standby_in ? `WFS_STATE_VBAT_SBY
                                       : `WFS_STATE_MAIN_SBY; // see RL9

   // Wake-up overrides; clear refreshes to plain active
   assign next_dev_state = standby_wake_in ? wake_state
                         : clear_hit       ? `WFS_STATE_ACTIVE
                         :                   dev_state; // see RL10

   ////////////////////////////////////////////////////////////////////////
   // Latched state

   // Flags come up with the power-on flag already set
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags <= wfs_word_t'(`WFS_FLAG_RESET); // see RL16
      end else begin
         flags <= next_flags;
      end
   end

   // State field changes only on a standby wake-up or a read-and-clear access
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dev_state <= `WFS_STATE_ACTIVE; // see RL9
      end else begin
         dev_state <= next_dev_state; // see RL10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counters

   // Events passed to the counter block
   assign cnt_bus.restart_event = main_regulator_restart_in; // see RL7
   assign cnt_bus.wd_fail       = watchdog_fail_in;          // see RL8
   assign cnt_bus.wd_trigger_ok = watchdog_trigger_ok_in;    // see RL8
   assign restart_count         = cnt_bus.restart_count;
   assign wd_count              = cnt_bus.wd_count;

   wfs_counters #(
      .RESTART_WIN_CYC (RESTART_WIN_CYC)
   ) u_counters (
      .ref_clk_in      (ref_clk_in),
      .rst_in          (rst_in),
      .cnt             (cnt_bus.counters)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path

   // Assembled register image
   assign contents = flags
      | wfs_field(`WFS_RESTART_LSB, {1'b0, restart_count}) // see RL7
      | wfs_field(`WFS_WDCNT_LSB,   wd_count)              // see RL8
      | wfs_field(`WFS_STATE_LSB,   {2'h0, dev_state});    // see RL9

   // Answer holds pre-clear contents; writes return nothing
   assign next_rd_data     = (read_hit || clear_hit) ? contents
                                                     : rd_data_out;
   assign next_rd_valid    = read_hit || clear_hit;  // see RL18
   assign next_invalid_cmd = write_hit;              // see RL17

   // Answer registers
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out     <= '0;
         rd_valid_out    <= 1'b0;
         invalid_cmd_out <= 1'b0;
      end else begin
         rd_data_out     <= next_rd_data;
         rd_valid_out    <= next_rd_valid;
         invalid_cmd_out <= next_invalid_cmd; // see RL17
      end
   end

endmodule : wfs_status

// >>> sim/wfs_host_model.sv
// Host side model issuing register accesses
`timescale 1ns/1ps
`include "wfs_defines.svh"

module wfs_host_model (
   input  wire logic                   ref_clk_in,
   output logic                        acc_valid_out,
   output logic [`WFS_ADDR_W-1:0]      acc_addr_out,
   output wfs_pkg::wfs_op_e            acc_op_out,
   input  wire logic [`WFS_DATA_W-1:0] rd_data_in,
   input  wire logic                   rd_valid_in,
   input  wire logic                   invalid_cmd_in
);
   import wfs_pkg::*;
   // Idle bus at time zero
   initial begin
      acc_valid_out = 1'b0;
      acc_addr_out = 6'h3F;
      acc_op_out = WFS_OP_NONE;
   end
   // One access, entered just after a rising edge
   task automatic xfer(input wfs_op_e op, input logic [5:0] addr,
                       output logic [23:0] data, output logic [1:0] ans);
      acc_valid_out <= 1'b1;
      acc_addr_out <= addr;
      acc_op_out <= op; // Writes only when told
      @(posedge ref_clk_in);
      acc_valid_out <= 1'b0;
      acc_addr_out <= ~addr; // Released lines do not keep old value
      acc_op_out <= wfs_op_e'(~op);
      #1;
      data = rd_data_in;
      ans = {rd_valid_in, invalid_cmd_in};
   endtask : xfer
endmodule : wfs_host_model

// >>> sim/wfs_status_assertions.sv
// Port assertions for the wake and fault status register
`timescale 1ns/1ps
`include "wfs_defines.svh"

module wfs_status_assertions (
   input wire logic                   ref_clk_in,
   input wire logic                   rst_in,
   input wire logic                   ext_irq_two_wake_in,
   input wire logic                   standby_wake_in,
   input wire logic                   watchdog_fail_in,
   input wire logic                   watchdog_trigger_ok_in,
   input wire logic                   acc_valid_in,
   input wire logic [`WFS_ADDR_W-1:0] acc_addr_in,
   input wire wfs_pkg::wfs_op_e       acc_op_in,
   input wire logic [`WFS_DATA_W-1:0] rd_data_out,
   input wire logic                   rd_valid_out,
   input wire logic                   invalid_cmd_out
);
   import wfs_pkg::*;
   // Decoded requests to the status address
   wire logic hit    = acc_valid_in && acc_addr_in == `WFS_ADDR_STATUS;
   wire logic rd_req = hit && !acc_op_in[1];
   wire logic rc_req = hit && acc_op_in == WFS_OP_READ_CLEAR;
   wire logic wr_req = hit && acc_op_in == WFS_OP_WRITE;
   wire logic quiet  = !watchdog_fail_in && !watchdog_trigger_ok_in;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // Answers, refusals and image contents
   rd_answer_a:
      assert property (rd_req |=> rd_valid_out)
      else $error("read not answered");
   wr_refuse_a:
      assert property (wr_req |=> invalid_cmd_out && !rd_valid_out)
      else $error("write not refused");
   wr_cause_a:
      assert property (invalid_cmd_out |-> $past(wr_req))
      else $error("refusal without write");
   reserved_zero_a:
      assert property (rd_valid_out |-> rd_data_out[22:21] == 2'h0)
      else $error("reserved bits set");
   data_hold_a:
      assert property (!rd_valid_out |-> $stable(rd_data_out))
      else $error("read data moved without read");
   irq_two_seen_a:
      assert property (ext_irq_two_wake_in ##1 !rc_req ##1 rd_req
                       |=> rd_data_out[23])
      else $error("interrupt two wake not latched");
   wd_fail_seen_a:
      assert property (watchdog_fail_in ##1 !rc_req && !watchdog_trigger_ok_in
                       ##1 rd_req |=> rd_data_out[1] && rd_data_out[11:8] != 4'h0)
      else $error("watchdog failure not recorded");
   state_refresh_a:
      assert property (rc_req && !standby_wake_in ##1 !standby_wake_in
                       ##1 rd_req |=> rd_data_out[7:6] == 2'h0)
      else $error("state not refreshed");
   wd_count_kept_a:
      assert property (rc_req && quiet ##1 quiet ##1 rd_req
                       |=> rd_data_out[11:8] == $past(rd_data_out[11:8], 2))
      else $error("watchdog count changed by clear");
endmodule : wfs_status_assertions

//////////////////////////////////////////////////////////////////////////////
bind wfs_status wfs_status_assertions chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in),
   .ext_irq_two_wake_in(ext_irq_two_wake_in),
   .standby_wake_in(standby_wake_in), .watchdog_fail_in(watchdog_fail_in),
   .watchdog_trigger_ok_in(watchdog_trigger_ok_in),
   .acc_valid_in(acc_valid_in), .acc_addr_in(acc_addr_in),
   .acc_op_in(acc_op_in), .rd_data_out(rd_data_out),
   .rd_valid_out(rd_valid_out), .invalid_cmd_out(invalid_cmd_out)
);

// >>> sim/wfs_status_test.sv
// Self-checking bench for the wake and fault status register
`timescale 1ns/1ps
`include "wfs_defines.svh"

module wfs_status_test;
   import wfs_pkg::*;
   localparam int unsigned WIN = 20;
   localparam logic [5:0]  A   = `WFS_ADDR_STATUS;
   localparam wfs_op_e     RD  = WFS_OP_READ;
   localparam wfs_op_e     RC  = WFS_OP_READ_CLEAR;
   logic        ref_clk_in  = 1'b0;
   logic        rst_in      = 1'b1;
   logic [23:0] ev          = '0;
   logic [23:0] flags       = `WFS_FLAG_RESET;
   logic [23:0] got;
   logic [23:0] rd_data;
   logic [5:0]  acc_addr;
   logic [3:0]  wcnt        = 4'h0;
   logic [2:0]  rcnt        = 3'h0;
   logic [1:0]  state       = 2'h0;
   logic [1:0]  ans;
   logic        acc_valid;
   logic        rd_valid;
   logic        inv_cmd;
   wfs_op_e     acc_op;
   int          n_mismatch  = 0;
   int          checks_done = 0;

   // 25 MHz clock
   always #20 ref_clk_in = ~ref_clk_in;

   // Flag event inputs sit at their flag positions in ev; restart, trigger and standby inputs in bits 13:12 and 7:6
   wfs_status #(.RESTART_WIN_CYC(WIN)) dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .ext_irq_two_wake_in(ev[23]), .ext_irq_one_wake_in(ev[20]),
      .can_wake_in(ev[19]), .lin_wake_in(ev[18]), .timer_wake_in(ev[17]),
      .debug_active_in(ev[16]), .main_regulator_uv_in(ev[15]),
      .thermal_stage_two_in(ev[5]), .thermal_stage_one_in(ev[4]),
      .forced_sleep_thermal_in(ev[3]), .forced_sleep_watchdog_in(ev[2]),
      .watchdog_fail_in(ev[1]), .power_on_reset_in(ev[0]),
      .main_regulator_restart_in(ev[12]), .watchdog_trigger_ok_in(ev[13]),
      .standby_wake_in(ev[6]), .vbat_standby_in(ev[7]),
      .acc_valid_in(acc_valid), .acc_addr_in(acc_addr), .acc_op_in(acc_op),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .invalid_cmd_out(inv_cmd)
   );
   wfs_host_model host (
      .ref_clk_in(ref_clk_in), .acc_valid_out(acc_valid),
      .acc_addr_out(acc_addr), .acc_op_out(acc_op), .rd_data_in(rd_data),
      .rd_valid_in(rd_valid), .invalid_cmd_in(inv_cmd)
   );

   // Expected image and its update by one cycle of events
   function automatic logic [23:0] image();
      return flags | {9'h000, rcnt, wcnt, state, 6'h00};
   endfunction : image
   function automatic void apply(input logic [23:0] e);
      flags = flags | (e & `WFS_FLAG_MASK);
      if (e[12] && rcnt != 3'h7) rcnt = rcnt + 3'h1;
      if (e[1] && wcnt != 4'hF) wcnt = wcnt + 4'h1;
      else if (e[13] && !e[1]) wcnt = 4'h0;
      if (e[6]) state = e[7] ? 2'h2 : 2'h1;
   endfunction : apply

   task automatic check(input string what, input logic [23:0] exp_v, act);
      checks_done++;
      if (exp_v !== act) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp_v, act);
      end
   endtask : check

   // Access with events driven in the same cycle
   task automatic acc(input wfs_op_e op, input logic [5:0] a,
                      input logic [23:0] e);
      logic [23:0] img;
      logic [1:0]  want;
      img = image();
      want = (a != A || op == WFS_OP_NONE) ? 2'b00 :
             (op == WFS_OP_WRITE) ? 2'b01 : 2'b10;
      @(posedge ref_clk_in);
      ev <= e;
      fork
         host.xfer(op, a, got, ans);
         begin
            @(posedge ref_clk_in);
            ev <= '0;
         end
      join
      check("answer", {22'h0, want}, {22'h0, ans});
      if (want[1]) check("image", img, got);
      if (want[1]) check("reserved", 24'h0, got & 24'h600000);
      if (want[1] && op == RC) begin
         flags = 24'h0;
         state = 2'h0;
      end
      apply(e);
   endtask : acc

   task automatic pulse(input logic [23:0] e);
      @(posedge ref_clk_in);
      ev <= e;
      @(posedge ref_clk_in);
      ev <= '0;
      apply(e);
   endtask : pulse

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Cut a hang short
   initial begin
      #(40 * 3000);
      n_mismatch++;
      wrap_up();
   end

   // Directed corners, random traffic, then other-address, write and idle accesses
   initial begin
      logic [23:0] e;
      wfs_op_e     op;
      void'($urandom(32'h3724));
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      acc(RC, A, '0);
      acc(RD, A, '0);
      acc(RD, A, 24'h800000);
      acc(RD, A, '0);
      repeat (9) pulse(24'h001000);
      acc(RC, A, '0);
      acc(RD, A, '0);
      repeat (WIN + 5) @(posedge ref_clk_in);
      rcnt = 3'h0;
      acc(RD, A, '0);
      repeat (16) pulse(24'h000002);
      acc(RD, A, 24'h002002);
      acc(RD, A, 24'h002000);
      for (int v = 0; v < 2; v++) begin
         acc(RD, A, {16'h0, v[0], 7'h40});
         acc(RC, A, '0);
      end
      repeat (40) begin
         e = 24'h1 << $urandom_range(23, 0);
         if (e[12]) e = '0;
         op = wfs_op_e'(2'($urandom_range(1, 0)));
         acc(op, A, e);
      end
      for (int o = 0; o < 4; o++) acc(wfs_op_e'(o), 6'h09, '0);
      acc(WFS_OP_WRITE, A, '0);
      acc(WFS_OP_NONE, A, '0);
      acc(RD, A, '0);
      wrap_up();
   end
endmodule : wfs_status_test
